// >>> dport_pkg.sv
// Shared constants, register map and state layout for the digital port block.
package dport_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int NUM_PORTS = 4;
  localparam int PORT_BITS = 8;
  localparam int NUM_GROUPS = 2;

  // Lines that physically exist on each port; narrower ports clear their upper lines.
  localparam logic [31:0] LINE_MASK = 32'hffffffff;
  // Ports whose own handshake circuitry can latch data.
  localparam logic [3:0] HS_CAPABLE = 4'h3;
  // On the group-capable build handshaking is reached only through group setup.
  localparam logic GROUP_VARIANT = 1'b1;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_LINE_WR = 8'h00;
  localparam logic [7:0] ADDR_PORT_WR = 8'h04;
  localparam logic [7:0] ADDR_PORT_CFG = 8'h08;
  localparam logic [7:0] ADDR_GRP_CFG = 8'h0c;
  localparam logic [7:0] ADDR_GRP_WR0 = 8'h10;
  localparam logic [7:0] ADDR_GRP_WR1 = 8'h14;
  localparam logic [7:0] ADDR_ERR = 8'h18;
  localparam logic [7:0] ADDR_PORT_RD = 8'h1c;
  localparam logic [7:0] ADDR_HS_QUERY = 8'h20;
  localparam logic [7:0] ADDR_CFG_RD = 8'h24;

  // ==========================================================================
  // Field positions in write data
  // ==========================================================================
  localparam int F_STATE = 0;
  localparam int F_LINE_LSB = 4;
  localparam int F_PORT_LSB = 8;
  localparam int F_DIR = 0;
  localparam int F_MODE = 1;
  localparam int F_GSIZE_LSB = 0;
  localparam int F_GBASE_LSB = 4;
  localparam int F_GDIR = 6;
  localparam int F_GMODE = 7;
  localparam int F_GSEL = 8;

  // Error register bits.
  localparam int ERR_BIT_ANY = 0;
  localparam int ERR_BIT_WRITE = 1;
  localparam int ERR_BIT_CFG = 2;
  localparam int ERR_BIT_QUERY = 3;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] in_latch;
    logic [3:0] dir;
    logic [3:0] mode;
    logic [1:0][2:0] gsize;
    logic [1:0][1:0] gbase;
    logic [1:0] gdir;
    logic [1:0] gmode;
    logic [3:0] hs;
    logic hs_res;
    logic [3:0] err;
    logic [31:0] rdata;
  } state_type;

  // All ports input, no handshake, no group members.
  localparam state_type STATE_RESET = '0;

endpackage : dport_pkg

// >>> group_word_mapper.sv
// Spreads a group data word over the member ports, lowest port taking the highest byte in use.
`timescale 1ns/1ps
module group_word_mapper
  import dport_pkg::*;
(
  input wire logic [2:0] i_size,
  input wire logic [1:0] i_base,
  input wire logic [31:0] i_word,
  output logic [NUM_PORTS-1:0] o_en,
  output logic [31:0] o_data
);

  // ==========================================================================
  // Per-port lane selection
  // ==========================================================================
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_lane
    localparam logic [1:0] PIDX = 2'(p);
    logic [1:0] byte_idx;
    logic [31:0] shifted;
    // The highest member port takes byte 0, so the byte index counts down from it.
    assign byte_idx = i_base + i_size[1:0] - 2'h1 - PIDX;
    assign shifted = i_word >> {byte_idx, 3'b000};
    assign o_en[p] = (i_size != 3'h0) && ({2'b00, PIDX} >= {2'b00, i_base}) &&
                     ({2'b00, PIDX} < ({2'b00, i_base} + {1'b0, i_size}));
    assign o_data[8*p +: 8] = o_en[p] ? shifted[7:0] : 8'h00;
  end

endmodule : group_word_mapper

// >>> digital_port_group_output.sv
// Digital port block with per-port and group output writes over APB.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - A one-port group takes the low eight bits of the word.
// - Two-port group: low byte to higher port, next byte to lower port.
// - Four-port group: bits 7:0 port 3 up to bits 31:24 port 0.
// - All ports of a group change together in one cycle.
// - Group write refused with error if group not output or empty.
// - Line write drives chosen line to state, other lines kept.
// - Line and port writes refused with error unless port is output and not in a group.
// - Data bit 0 drives line 0; narrow ports use only low bits.
// - Each port holds a direction: 0 input, 1 output.
// - Each port holds a mode: 0 plain, 1 latched handshake.
// - Port setup accepts handshake mode only on handshake-capable ports of a build without groups; group setup accepts it on any port.
// - Invalid port setup refused with error, old setup kept.
// - Port setup refused with error when port belongs to a group.
// - After reset all ports input, plain mode, no groups.
// - On the group build, individual setup offers only plain mode.
// - Handshake status shows latched input or taken output data.
// - Status query of non-handshake port returns 0 and error.
// - Reading an output port returns the levels it drives.
module digital_port_group_output
  import dport_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [31:0] i_port_in,
  input wire logic [3:0] i_stb,
  input wire logic [3:0] i_ack,
  output logic [31:0] o_port_out,
  output logic [31:0] o_port_oe,
  output logic o_err
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [3:0] owns(input logic [2:0] size, input logic [1:0] base);
    logic [3:0] r;
    r = 4'h0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      r[p] = (size != 3'h0) && (p >= int'(base)) && (p < int'(base) + int'(size));
    end
    return r;
  endfunction : owns

  // Group setting wins over the port's own setting while the port is a member.
  function automatic logic [3:0] eff_bits(input state_type s, input logic use_mode);
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] r;
    a = owns(s.gsize[0], s.gbase[0]);
    b = owns(s.gsize[1], s.gbase[1]);
    r = 4'h0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (a[p]) begin
        r[p] = use_mode ? s.gmode[0] : s.gdir[0];
      end else if (b[p]) begin
        r[p] = use_mode ? s.gmode[1] : s.gdir[1];
      end else begin
        r[p] = use_mode ? s.mode[p] : s.dir[p];
      end
    end
    return r;
  endfunction : eff_bits

  function automatic logic [31:0] oe_of(input state_type s);
    logic [3:0] d;
    logic [31:0] r;
    d = eff_bits(s, 1'b0);
    r = 32'h0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      r[8*p +: 8] = {8{d[p]}} & LINE_MASK[8*p +: 8];
    end
    return r;
  endfunction : oe_of

  // ==========================================================================
  // Decoded request
  // ==========================================================================
  state_type s_q;
  state_type s_d;
  logic acc_wr;
  logic acc_rd;
  logic setup_rd;
  logic mapped;
  logic [1:0] port_sel;
  logic [2:0] line_sel;
  logic [4:0] line_bit;
  logic [31:0] mask_sh;
  logic [7:0] lane_mask;
  logic [3:0] own0;
  logic [3:0] own1;
  logic [3:0] in_grp;
  logic [3:0] eff_dir;
  logic [3:0] eff_mode;
  logic port_out_ok;
  logic line_ok;
  logic mode_ok;
  logic cfg_ok;
  logic gsel;
  logic [2:0] gsize_new;
  logic [1:0] gbase_new;
  logic [3:0] new_own;
  logic gcfg_ok;
  logic gwr_addr;
  logic gidx;
  logic [2:0] gwr_size;
  logic gwr_ok;
  logic [3:0] grp_en;
  logic [31:0] grp_data;
  logic [31:0] grp_mask;
  logic refused;

  assign acc_wr = i_psel && i_penable && i_pwrite;
  assign acc_rd = i_psel && i_penable && !i_pwrite;
  assign setup_rd = i_psel && !i_penable && !i_pwrite;
  assign port_sel = i_pwdata[F_PORT_LSB +: 2];
  assign line_sel = i_pwdata[F_LINE_LSB +: 3];
  assign line_bit = {port_sel, line_sel};
  assign mask_sh = LINE_MASK >> {port_sel, 3'b000};
  assign lane_mask = mask_sh[7:0];
  assign own0 = owns(s_q.gsize[0], s_q.gbase[0]);
  assign own1 = owns(s_q.gsize[1], s_q.gbase[1]);
  assign in_grp = own0 | own1;
  assign eff_dir = eff_bits(s_q, 1'b0);
  assign eff_mode = eff_bits(s_q, 1'b1);

  // Group members are reachable only through group writes.
  assign port_out_ok = !in_grp[port_sel] && eff_dir[port_sel];
  assign line_ok = port_out_ok && lane_mask[line_sel];
  assign mode_ok = !i_pwdata[F_MODE] || (HS_CAPABLE[port_sel] && !GROUP_VARIANT);
  assign cfg_ok = !in_grp[port_sel] && mode_ok;

  assign gsel = i_pwdata[F_GSEL];
  assign gsize_new = i_pwdata[F_GSIZE_LSB +: 3];
  assign gbase_new = i_pwdata[F_GBASE_LSB +: 2];
  assign new_own = owns(gsize_new, gbase_new);
  // Size 0 (empty) or sizes 1, 2 and 4, naturally aligned, never overlapping the other group.
  assign gcfg_ok = ((gsize_new == 3'h0) || (gsize_new == 3'h1) ||
                    ((gsize_new == 3'h2) && !gbase_new[0]) ||
                    ((gsize_new == 3'h4) && (gbase_new == 2'h0))) &&
                   ((new_own & (gsel ? own0 : own1)) == 4'h0);

  assign gwr_addr = (i_paddr == ADDR_GRP_WR0) || (i_paddr == ADDR_GRP_WR1);
  assign gidx = (i_paddr == ADDR_GRP_WR1);
  assign gwr_size = s_q.gsize[gidx];
  assign gwr_ok = (gwr_size != 3'h0) && s_q.gdir[gidx];

  // Every refusal raises the summary bit, even when its detail bit is already set.
  assign refused = acc_wr && (((i_paddr == ADDR_LINE_WR) && !line_ok) ||
                   ((i_paddr == ADDR_PORT_WR) && !port_out_ok) ||
                   ((i_paddr == ADDR_PORT_CFG) && !cfg_ok) || ((i_paddr == ADDR_GRP_CFG) && !gcfg_ok) ||
                   (gwr_addr && !gwr_ok) || ((i_paddr == ADDR_HS_QUERY) && !eff_mode[port_sel]));

  group_word_mapper u_mapper (
    .i_size(gwr_size),
    .i_base(s_q.gbase[gidx]),
    .i_word(i_pwdata),
    .o_en(grp_en),
    .o_data(grp_data)
  );

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_gmask
    assign grp_mask[8*p +: 8] = {8{grp_en[p]}} & LINE_MASK[8*p +: 8];
  end

  always_comb begin
    if (i_paddr == ADDR_LINE_WR || i_paddr == ADDR_PORT_WR || i_paddr == ADDR_PORT_CFG) begin
      mapped = 1'b1;
    end else if (i_paddr == ADDR_GRP_CFG || gwr_addr || i_paddr == ADDR_ERR) begin
      mapped = 1'b1;
    end else if (i_paddr == ADDR_PORT_RD || i_paddr == ADDR_HS_QUERY || i_paddr == ADDR_CFG_RD) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_d = s_q;
    if (acc_wr) begin
      if (i_paddr == ADDR_LINE_WR) begin
        if (line_ok) begin
          s_d.out[line_bit] = i_pwdata[F_STATE];
        end else begin
          s_d.err[ERR_BIT_WRITE] = 1'b1;
        end
      end else if (i_paddr == ADDR_PORT_WR) begin
        if (port_out_ok) begin
          s_d.out[{port_sel, 3'b000} +: 8] = i_pwdata[7:0] & lane_mask;
          s_d.hs[port_sel] = 1'b0;
        end else begin
          s_d.err[ERR_BIT_WRITE] = 1'b1;
        end
      end else if (i_paddr == ADDR_PORT_CFG) begin
        if (cfg_ok) begin
          s_d.dir[port_sel] = i_pwdata[F_DIR];
          s_d.mode[port_sel] = i_pwdata[F_MODE];
          s_d.hs[port_sel] = 1'b0;
        end else begin
          s_d.err[ERR_BIT_CFG] = 1'b1;
        end
      end else if (i_paddr == ADDR_GRP_CFG) begin
        if (gcfg_ok) begin
          s_d.gsize[gsel] = gsize_new;
          s_d.gbase[gsel] = gbase_new;
          s_d.gdir[gsel] = i_pwdata[F_GDIR];
          s_d.gmode[gsel] = i_pwdata[F_GMODE];
        end else begin
          s_d.err[ERR_BIT_CFG] = 1'b1;
        end
      end else if (gwr_addr) begin
        if (gwr_ok) begin
          // One assignment for every member so no port moves ahead of another.
          s_d.out = (s_q.out & ~grp_mask) | (grp_data & grp_mask);
          s_d.hs = s_q.hs & ~grp_en;
        end else begin
          s_d.err[ERR_BIT_WRITE] = 1'b1;
        end
      end else if (i_paddr == ADDR_HS_QUERY) begin
        if (eff_mode[port_sel]) begin
          s_d.hs_res = s_q.hs[port_sel];
        end else begin
          s_d.hs_res = 1'b0;
          s_d.err[ERR_BIT_QUERY] = 1'b1;
        end
      end else if (i_paddr == ADDR_ERR) begin
        s_d.err = s_q.err & ~i_pwdata[3:0];
      end
    end
    // A clear only lowers bits, so it must never count as a new refusal.
    if (refused) begin
      s_d.err[ERR_BIT_ANY] = 1'b1;
    end
    if (acc_rd && i_paddr == ADDR_PORT_RD) begin
      s_d.hs = s_d.hs & ~(eff_mode & ~eff_dir);
    end
    // Handshake events are applied last so an event never loses to a clear.
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (eff_mode[p] && !eff_dir[p] && i_stb[p]) begin
        s_d.hs[p] = 1'b1;
        s_d.in_latch[8*p +: 8] = i_port_in[8*p +: 8];
      end
      if (eff_mode[p] && eff_dir[p] && i_ack[p]) begin
        s_d.hs[p] = 1'b1;
      end
    end
    // Read data is captured in the setup cycle so the access phase needs no wait.
    if (setup_rd) begin
      if (i_paddr == ADDR_PORT_RD) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (eff_dir[p]) begin
            s_d.rdata[8*p +: 8] = s_q.out[8*p +: 8];
          end else if (eff_mode[p]) begin
            s_d.rdata[8*p +: 8] = s_q.in_latch[8*p +: 8];
          end else begin
            s_d.rdata[8*p +: 8] = i_port_in[8*p +: 8] & LINE_MASK[8*p +: 8];
          end
        end
      end else if (i_paddr == ADDR_CFG_RD) begin
        s_d.rdata = {8'h00, s_q.gmode, s_q.gdir, s_q.gbase[1], s_q.gbase[0], 1'b0, s_q.gsize[1],
                     1'b0, s_q.gsize[0], s_q.mode, s_q.dir};
      end else if (i_paddr == ADDR_ERR) begin
        s_d.rdata = {28'h0, s_q.err};
      end else if (i_paddr == ADDR_HS_QUERY) begin
        s_d.rdata = {31'h0, s_q.hs_res};
      end else begin
        s_d.rdata = 32'h0;
      end
    end
    s_d.oe = oe_of(s_d);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata = s_q.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_port_out = s_q.out;
  assign o_port_oe = s_q.oe;
  assign o_err = s_q.err[ERR_BIT_ANY];

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence grp4_write;
    acc_wr && gwr_addr && gwr_ok && (gwr_size == 3'h4);
  endsequence
  sequence grp2_low_write;
    acc_wr && gwr_addr && gwr_ok && (gwr_size == 3'h2) && (s_q.gbase[gidx] == 2'h0);
  endsequence
  sequence port_rd_setup;
    setup_rd && (i_paddr == ADDR_PORT_RD);
  endsequence

  group_four_a: assert property (grp4_write |=> s_q.out == ({$past(i_pwdata[7:0]), $past(i_pwdata[15:8]),
      $past(i_pwdata[23:16]), $past(i_pwdata[31:24])} & LINE_MASK)) else $error("four-port group mapping wrong");
  group_two_a: assert property (grp2_low_write |=> (s_q.out[15:0] == ({$past(i_pwdata[7:0]),
      $past(i_pwdata[15:8])} & LINE_MASK[15:0])) && $stable(s_q.out[31:16])) else $error("two-port group mapping wrong");
  group_one_a: assert property (acc_wr && gwr_addr && gwr_ok && (gwr_size == 3'h1) |=>
      (s_q.out & $past(grp_mask)) == ({4{$past(i_pwdata[7:0])}} & $past(grp_mask))) else $error("one-port group wrong");
  group_refuse_a: assert property (acc_wr && gwr_addr && !gwr_ok |=> $stable(s_q.out) &&
      s_q.err[ERR_BIT_WRITE] && s_q.err[ERR_BIT_ANY]) else $error("bad group write not refused");
  line_write_a: assert property (acc_wr && (i_paddr == ADDR_LINE_WR) && line_ok |=>
      s_q.out == (($past(s_q.out) & ~(32'h1 << $past(line_bit))) | ({31'h0, $past(i_pwdata[0])} << $past(line_bit))))
      else $error("line write changed wrong bits");
  write_refuse_a: assert property (acc_wr && (((i_paddr == ADDR_LINE_WR) && !line_ok) ||
      ((i_paddr == ADDR_PORT_WR) && !port_out_ok)) |=> $stable(s_q.out) ##0 s_q.err[ERR_BIT_WRITE])
      else $error("write to non-output port not refused");
  port_write_a: assert property (acc_wr && (i_paddr == ADDR_PORT_WR) && port_out_ok |=>
      ((s_q.out >> {$past(port_sel), 3'b000}) & 32'hff) == {24'h0, $past(i_pwdata[7:0]) & $past(lane_mask)})
      else $error("port write lane wrong");
  cfg_keep_a: assert property (acc_wr && (i_paddr == ADDR_PORT_CFG) && !cfg_ok |=> $stable(s_q.dir) &&
      $stable(s_q.mode) && s_q.err[ERR_BIT_CFG]) else $error("refused setup changed the port");
  plain_only_a: assert property (GROUP_VARIANT |-> s_q.mode == 4'h0) else $error("port mode set individually");
  reset_cfg_a: assert property (disable iff (1'b0) !i_nrst |=> (s_q.dir == 4'h0) && (s_q.mode == 4'h0) &&
      (s_q.gsize == '0) && (o_port_oe == 32'h0)) else $error("reset setup wrong");
  query_plain_a: assert property (acc_wr && (i_paddr == ADDR_HS_QUERY) && !eff_mode[port_sel] |=>
      !s_q.hs_res && s_q.err[ERR_BIT_QUERY]) else $error("plain port query not refused");
  readback_a: assert property (port_rd_setup |=> ((s_q.rdata & s_q.oe) == (s_q.out & s_q.oe)) ##0 o_pready)
      else $error("read-back of output port wrong");
  err_sticky_a: assert property (s_q.err[ERR_BIT_ANY] && !(acc_wr && (i_paddr == ADDR_ERR) && i_pwdata[0]) |=>
      s_q.err[ERR_BIT_ANY]) else $error("error flag lost");
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_hs_chk
    hs_latch_a: assert property (eff_mode[p] && !eff_dir[p] && i_stb[p] |=> s_q.hs[p] &&
        (s_q.in_latch[8*p +: 8] == $past(i_port_in[8*p +: 8]))) else $error("input handshake not latched");
  end

endmodule : digital_port_group_output

// >>> ext_equipment.sv
// Behavioural model of the external equipment wired to the port lines.
`timescale 1ns/1ps
module ext_equipment
  import dport_pkg::*;
(
  input wire logic i_clk,
  input wire logic [31:0] i_port_out,
  input wire logic [31:0] i_port_oe,
  output logic [31:0] o_port_in,
  output logic [3:0] o_stb,
  output logic [3:0] o_ack
);
  // ==========================================================================
  // Line levels
  // ==========================================================================
  // Undriven lanes toggle every cycle unless held for a strobe, so a stale value can never pass for data.
  logic [31:0] pattern_q = 32'h5a5a5a5a;
  logic [31:0] hold_data = 32'h00000000;
  logic [3:0] hold = 4'h0;
  initial o_stb = 4'h0;
  initial o_ack = 4'h0;
  always @(posedge i_clk) pattern_q <= ~pattern_q;
  always_comb begin
    for (int b = 0; b < 32; b++) begin
      o_port_in[b] = i_port_oe[b] ? i_port_out[b] : (hold[b/8] ? hold_data[b] : pattern_q[b]);
    end
  end
  // ==========================================================================
  // Handshake events
  // ==========================================================================
  task automatic strobe(input int p, input logic [7:0] d);
    @(posedge i_clk);
    hold_data[8*p+:8] <= d;
    hold[p] <= 1'b1;
    o_stb[p] <= 1'b1;
    @(posedge i_clk);
    o_stb[p] <= 1'b0;
    @(posedge i_clk);
    hold[p] <= 1'b0;
  endtask : strobe
  task automatic acknowledge(input int p);
    @(posedge i_clk);
    o_ack[p] <= 1'b1;
    @(posedge i_clk);
    o_ack[p] <= 1'b0;
  endtask : acknowledge
endmodule : ext_equipment

// >>> tb.sv
// Self-checking testbench for the digital port block.
`timescale 1ns/1ps
module tb;
  import dport_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] o_prdata, o_port_out, o_port_oe, port_in, rdata, exp_out, w;
  logic o_pready, o_pslverr, o_err, slverr;
  logic [3:0] stb, ack;
  int err_count = 0;
  int comparisons = 0;
  integer seed = 32'h124b88d2;
  int p, sz, bs;
  always #2.5 i_clk = ~i_clk;
  digital_port_group_output i_digital_port_group_output (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_port_in(port_in), .i_stb(stb), .i_ack(ack),
    .o_port_out(o_port_out), .o_port_oe(o_port_oe), .o_err(o_err));
  ext_equipment i_ext_equipment (.i_clk(i_clk), .i_port_out(o_port_out), .i_port_oe(o_port_oe),
    .o_port_in(port_in), .o_stb(stb), .o_ack(ack));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] grp_map(input int size, input int base, input logic [31:0] wd,
      input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < size; k++) r[8*(base+size-1-k)+:8] = wd[8*k+:8];
    return r;
  endfunction : grp_map
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rdata = o_prdata;
    slverr = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rdata);
  endtask : rdchk
  task automatic complete_run;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    rdchk(ADDR_CFG_RD, 32'h0, "cfg after reset");
    chk("oe after reset", 32'h0, o_port_oe);
    apb(1'b1, ADDR_LINE_WR, 32'h00000111);
    chk("out after refused line", 32'h0, o_port_out);
    rdchk(ADDR_ERR, 32'h3, "err write refused");
    chk("err flag", 32'h1, {31'h0, o_err});
    apb(1'b1, ADDR_ERR, 32'hf);
    rdchk(ADDR_ERR, 32'h0, "err cleared");
    for (int i = 0; i < 4; i++) apb(1'b1, ADDR_PORT_CFG, (i << 8) | 32'h1);
    rdchk(ADDR_CFG_RD, 32'hf, "dir all out");
    chk("oe all out", 32'hffffffff, o_port_oe);
    // Latched mode must be refused on every port of this build, old setup kept.
    for (int i = 0; i < 4; i++) apb(1'b1, ADDR_PORT_CFG, (i << 8) | 32'h2);
    rdchk(ADDR_CFG_RD, 32'hf, "mode refused");
    rdchk(ADDR_ERR, 32'h5, "err cfg refused");
    apb(1'b1, ADDR_ERR, 32'hf);
    exp_out = 32'h0;
    for (int i = 0; i < 16; i++) begin
      p = $random(seed) & 3;
      w = $random(seed);
      apb(1'b1, ADDR_PORT_WR, {22'h0, p[1:0], w[7:0]});
      exp_out[8*p+:8] = w[7:0];
      chk("port write", exp_out, o_port_out);
      bs = $random(seed) & 7;
      apb(1'b1, ADDR_LINE_WR, {22'h0, p[1:0], 1'b0, bs[2:0], 3'h0, w[8]});
      exp_out[8*p+bs] = w[8];
      chk("line write", exp_out, o_port_out);
    end
    rdchk(ADDR_PORT_RD, exp_out, "read back");
    for (int i = 0; i < 4; i++) begin
      sz = (i == 0) ? 1 : ((i == 3) ? 4 : 2);
      bs = (i == 0) ? 1 : ((i == 2) ? 2 : 0);
      apb(1'b1, ADDR_GRP_CFG, 32'h40 | (bs << 4) | sz);
      w = $random(seed);
      apb(1'b1, ADDR_GRP_WR0, w);
      exp_out = grp_map(sz, bs, w, exp_out);
      chk("group write", exp_out, o_port_out);
      apb(1'b1, ADDR_PORT_CFG, bs << 8);
      rdchk(ADDR_CFG_RD, 32'h10000f | (bs << 16) | (sz << 8), "member cfg");
      rdchk(ADDR_ERR, 32'h5, "err member cfg");
      apb(1'b1, ADDR_ERR, 32'hf);
      apb(1'b1, ADDR_GRP_CFG, 32'h0);
    end
    apb(1'b1, ADDR_GRP_WR0, $random(seed));
    chk("empty group", exp_out, o_port_out);
    apb(1'b1, ADDR_GRP_CFG, 32'h131);
    apb(1'b1, ADDR_GRP_WR1, $random(seed));
    chk("input group", exp_out, o_port_out);
    rdchk(ADDR_ERR, 32'h3, "err group refused");
    apb(1'b1, ADDR_ERR, 32'hf);
    apb(1'b1, ADDR_GRP_CFG, 32'h100);
    apb(1'b1, ADDR_HS_QUERY, 32'h200);
    rdchk(ADDR_HS_QUERY, 32'h0, "plain query");
    rdchk(ADDR_ERR, 32'h9, "err query");
    apb(1'b1, ADDR_ERR, 32'hf);
    // Input handshake on port 0, output handshake on port 1.
    apb(1'b1, ADDR_GRP_CFG, 32'h81);
    apb(1'b1, ADDR_HS_QUERY, 32'h000);
    rdchk(ADDR_HS_QUERY, 32'h0, "nothing latched");
    w = $random(seed);
    i_ext_equipment.strobe(0, w[7:0]);
    apb(1'b1, ADDR_HS_QUERY, 32'h000);
    rdchk(ADDR_HS_QUERY, 32'h1, "data latched");
    apb(1'b0, ADDR_PORT_RD, 32'h0);
    chk("latched data", {24'h0, w[7:0]}, {24'h0, rdata[7:0]});
    apb(1'b1, ADDR_GRP_CFG, 32'h1d1);
    apb(1'b1, ADDR_GRP_WR1, w);
    exp_out = grp_map(1, 1, w, exp_out);
    chk("handshake group write", exp_out, o_port_out);
    apb(1'b1, ADDR_HS_QUERY, 32'h100);
    rdchk(ADDR_HS_QUERY, 32'h0, "output pending");
    i_ext_equipment.acknowledge(1);
    apb(1'b1, ADDR_HS_QUERY, 32'h100);
    rdchk(ADDR_HS_QUERY, 32'h1, "output taken");
    rdchk(ADDR_ERR, 32'h0, "no error");
    rdchk(8'hfc, 32'h0, "unmapped data");
    chk("unmapped slverr", 32'h1, {31'h0, slverr});
    complete_run();
  end
endmodule : tb
